// [logic/asr_ctrl.v]
// clocked controller driving an asynchronous 32k x 8 static ram
// Contract
// R1: memory stores data only while chip select and write strobe both low.
// R2: write ends when chip select or write strobe rises.
// R3: write data setup and hold referenced to the strobe rising edge.
// R4: strobe-controlled write with outputs enabled lasts float delay plus setup.
// R5: write strobe stays high for every read cycle.
// R6: read data valid within access time after address settles.
// R7: read data valid within access time after chip select falls.
// R8: read data valid within output-enable access after output enable falls.
// R9: standby entered within power-down time after chip select rises.
// R10: data lines float during writes while output enable is high.
// R11: select rising with strobe keeps outputs undriven.
// R12: controller never drives data lines while memory drives them.
// R13: address valid before or with chip select falling.
// R14: array is 32k words of 8 bits, 15-bit word index.
// R15: deselected memory ignores accesses, lines undriven.
// R16: output enable high floats lines; low while selected drives data.
// R17: contents preserved in standby and across reads.
// R18: minimum delays rounded up to whole controller clocks.
`include "asr_regs.vh"
module asr_ctrl #(
  parameter AW         = `ASR_ADDR_W,
  parameter DW         = `ASR_DATA_W,
  parameter CYC_ACCESS = `ASR_CYC_ACCESS,
  parameter CYC_CYCLE  = `ASR_CYC_CYCLE,
  parameter CYC_PWE    = `ASR_CYC_PWE,
  parameter CYC_SD     = `ASR_CYC_SD,
  parameter CYC_HZ     = `ASR_CYC_HZ
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          req_valid,
  input  wire          req_write,
  input  wire [AW-1:0] req_addr,
  input  wire [DW-1:0] req_wdata,
  output wire          req_ready,
  output reg  [DW-1:0] rsp_rdata,
  output reg           rsp_valid,
  output reg  [AW-1:0] word_index,
  output reg           chip_sel_n,
  output reg           write_strobe_n,
  output reg           out_drive_n,
  output reg  [DW-1:0] data_lines_o,
  output reg           data_lines_oe,
  input  wire [DW-1:0] data_lines_i
);
  // controller states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RD    = 3'h1;
  localparam [2:0] ST_RDHZ  = 3'h2;
  localparam [2:0] ST_WR    = 3'h3;
  localparam [2:0] ST_WREND = 3'h4;
  localparam [2:0] ST_REC   = 3'h5;

  // last count of each timed state, in clocks
  localparam [7:0] RD_LAST  = CYC_ACCESS[7:0] + 8'h01;
  localparam [7:0] HZ_LAST  = CYC_HZ[7:0];
  localparam [7:0] PWE_CYC  = (CYC_PWE > CYC_SD) ? CYC_PWE[7:0] : CYC_SD[7:0];
  localparam [7:0] WR_LAST  = PWE_CYC - 8'h01;
  localparam [7:0] REC_LAST = (CYC_CYCLE[7:0] > PWE_CYC) ? CYC_CYCLE[7:0] - PWE_CYC : 8'h00;

  reg [2:0]    state_r;
  reg [7:0]    cnt_r;
  reg [DW-1:0] sync1_r;
  reg [DW-1:0] sync2_r;

  // next values from the combinational block
  reg [2:0]    state_nxt;
  reg [7:0]    cnt_nxt;
  reg [DW-1:0] rdata_nxt;
  reg          valid_nxt;
  reg [AW-1:0] index_nxt;
  reg          sel_n_nxt;
  reg          strobe_n_nxt;
  reg          drive_n_nxt;
  reg [DW-1:0] wdata_nxt;
  reg          oe_nxt;

  // request accepted at this edge
  wire         take;
  wire         take_wr;
  wire         take_rd;

  // true once a timed state has run its full count
  function count_done;
    input [7:0] count;
    input [7:0] last;
    begin
      count_done = (count >= last);
    end
  endfunction

  assign req_ready = (state_r == ST_IDLE);
  assign take      = req_valid && req_ready;
  assign take_wr   = take && req_write;
  assign take_rd   = take && !req_write;

  // pins are asynchronous to clk
  always @(posedge clk) begin
    sync1_r <= data_lines_i;
    sync2_r <= sync1_r;
  end

  // next state and next pin levels
  always @* begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    rdata_nxt    = rsp_rdata;
    valid_nxt    = 1'b0;
    index_nxt    = word_index;
    sel_n_nxt    = chip_sel_n;
    strobe_n_nxt = write_strobe_n;
    drive_n_nxt  = out_drive_n;
    wdata_nxt    = data_lines_o;
    oe_nxt       = data_lines_oe;
    case (state_r)
      ST_IDLE: begin
        // pins parked: deselected, strobes high, bus released
        sel_n_nxt    = 1'b1; // R15
        strobe_n_nxt = 1'b1;
        drive_n_nxt  = 1'b1;
        oe_nxt       = 1'b0;
        if (take_wr) begin
          index_nxt    = req_addr; // R13 R14
          sel_n_nxt    = 1'b0; // R13
          strobe_n_nxt = 1'b0; // R1
          drive_n_nxt  = 1'b1; // R10
          wdata_nxt    = req_wdata;
          // memory outputs stay off in a write, so data goes out at once
          oe_nxt       = 1'b1; // R3 R12
          cnt_nxt      = 8'h00;
          state_nxt    = ST_WR;
        end else if (take_rd) begin
          index_nxt    = req_addr; // R13 R14
          sel_n_nxt    = 1'b0; // R13
          strobe_n_nxt = 1'b1; // R5
          drive_n_nxt  = 1'b0; // R16
          cnt_nxt      = 8'h00;
          state_nxt    = ST_RD;
        end
      end
      ST_RD: begin
        // access time plus two synchroniser stages
        cnt_nxt = cnt_r + 8'h01;
        if (count_done(cnt_r, RD_LAST)) begin // R6 R7 R8 R18
          rdata_nxt   = sync2_r;
          valid_nxt   = 1'b1;
          sel_n_nxt   = 1'b1; // R9 R15
          drive_n_nxt = 1'b1;
          cnt_nxt     = 8'h00;
          state_nxt   = ST_RDHZ;
        end
      end
      ST_RDHZ: begin
        // memory may still drive the lines for its float delay
        cnt_nxt = cnt_r + 8'h01;
        if (count_done(cnt_r, HZ_LAST)) begin // R12
          cnt_nxt   = 8'h00;
          state_nxt = ST_REC;
        end
      end
      ST_WR: begin
        // strobe long enough for pulse width and data setup
        cnt_nxt = cnt_r + 8'h01;
        if (count_done(cnt_r, WR_LAST)) begin // R3 R4 R18
          strobe_n_nxt = 1'b1; // R2 R3
          sel_n_nxt    = 1'b1; // R11
          cnt_nxt      = 8'h00;
          state_nxt    = ST_WREND;
        end
      end
      ST_WREND: begin
        // data held one clock past the strobe rise
        oe_nxt    = 1'b0; // R3
        cnt_nxt   = 8'h00;
        state_nxt = ST_REC;
      end
      ST_REC: begin
        // recovery until the full cycle time is met
        cnt_nxt = cnt_r + 8'h01;
        if (count_done(cnt_r, REC_LAST)) begin // R18
          cnt_nxt   = 8'h00;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        sel_n_nxt    = 1'b1;
        strobe_n_nxt = 1'b1;
        drive_n_nxt  = 1'b1;
        oe_nxt       = 1'b0;
        cnt_nxt      = 8'h00;
        state_nxt    = ST_IDLE;
      end
    endcase
  end

  // registered state, pins and response
  always @(posedge clk) begin
    if (rst) begin
      state_r        <= ST_IDLE;
      cnt_r          <= 8'h00;
      rsp_rdata      <= {DW{1'b0}};
      rsp_valid      <= 1'b0;
      word_index     <= {AW{1'b0}};
      chip_sel_n     <= 1'b1;
      write_strobe_n <= 1'b1;
      out_drive_n    <= 1'b1;
      data_lines_o   <= {DW{1'b0}};
      data_lines_oe  <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      cnt_r          <= cnt_nxt;
      rsp_rdata      <= rdata_nxt;
      rsp_valid      <= valid_nxt;
      word_index     <= index_nxt;
      chip_sel_n     <= sel_n_nxt;
      write_strobe_n <= strobe_n_nxt;
      out_drive_n    <= drive_n_nxt;
      data_lines_o   <= wdata_nxt;
      data_lines_oe  <= oe_nxt;
    end
  end
endmodule

// [common/asr_regs.vh]
// timing constants and pin layout for the static ram controller
`ifndef ASR_REGS_VH
`define ASR_REGS_VH
`define ASR_ADDR_W        15
`define ASR_DATA_W        8
`define ASR_CLK_PERIOD_NS 8
// fast grade figures in ns
`define ASR_T_CYCLE_NS    55
`define ASR_T_ACCESS_NS   55
`define ASR_T_OE_HZ_NS    20
`define ASR_T_PWE_NS      40
`define ASR_T_SD_NS       25
`define ASR_T_WE_HZ_NS    20
`define ASR_T_SA_NS       0
// minimum times rounded up to whole clocks
`define ASR_CEIL(t) (((t) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_CYC_ACCESS    (`ASR_CEIL(`ASR_T_ACCESS_NS) + 1)
`define ASR_CYC_CYCLE     `ASR_CEIL(`ASR_T_CYCLE_NS)
`define ASR_CYC_PWE       `ASR_CEIL(`ASR_T_WE_HZ_NS + `ASR_T_SD_NS)
`define ASR_CYC_SD        `ASR_CEIL(`ASR_T_SD_NS)
`define ASR_CYC_HZ        `ASR_CEIL(`ASR_T_OE_HZ_NS)
`endif

// [verification/asr_ctrl_asserts.sv]
// pin checks for the static ram controller
module asr_ctrl_asserts (
  input wire        clk,
  input wire        rst,
  input wire        rsp_valid,
  input wire [14:0] word_index,
  input wire        chip_sel_n,
  input wire        write_strobe_n,
  input wire        out_drive_n,
  input wire        data_lines_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_pulse;
    !write_strobe_n[*6] ##1 write_strobe_n;
  endsequence
  sequence s_rd_wait;
    !chip_sel_n[*7] ##[0:5] rsp_valid;
  endsequence
  rd_strobe_high_a: assert property (!chip_sel_n && !out_drive_n |-> write_strobe_n)
    else $error("strobe low in read");
  no_bus_fight_a: assert property (!(data_lines_oe && !chip_sel_n && !out_drive_n))
    else $error("bus contention");
  addr_hold_a: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(word_index))
    else $error("address moved");
  wr_pulse_len_a: assert property ($fell(write_strobe_n) |-> s_wr_pulse)
    else $error("write pulse length");
  wr_end_both_a: assert property ($rose(write_strobe_n) |-> $rose(chip_sel_n))
    else $error("write end");
  wr_data_setup_a: assert property ($rose(write_strobe_n) |-> data_lines_oe && $past(data_lines_oe, 4))
    else $error("data setup or hold");
  rd_access_wait_a: assert property ($fell(chip_sel_n) && write_strobe_n |-> s_rd_wait)
    else $error("read access");
  rd_release_a: assert property ($rose(out_drive_n) |-> !data_lines_oe[*3])
    else $error("drive before float");
  wr_out_off_a: assert property (!write_strobe_n |-> out_drive_n)
    else $error("outputs on in write");
endmodule

// [verification/asr_sram_model.sv]
// behavioural 32k x 8 asynchronous static ram
module asr_sram_model (
  input wire  [14:0] word_index,
  input wire         chip_sel_n,
  input wire         write_strobe_n,
  input wire         out_drive_n,
  input wire  [7:0]  din,
  output wire [7:0]  dout,
  output wire        drv
);
  timeunit 1ns;
  timeprecision 100ps;
  parameter T_ACC = 55;
  parameter T_OE  = 25;
  logic [7:0] mem [0:32767];
  wire [7:0] q;
  wire       wr = !chip_sel_n && !write_strobe_n;
  wire       en = !chip_sel_n && !out_drive_n && write_strobe_n;
  always @(negedge wr) mem[word_index] <= din;
  assign #T_ACC q = mem[word_index];
  assign #T_OE drv = en;
  // released lines show the inverse
  assign dout = drv ? q : ~q;
endmodule

// [verification/test_async_static_ram_32kx8.sv]
// self-checking bench for the static ram controller
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module test_async_static_ram_32kx8;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst = 1, req_valid = 0, req_write = 0;
  logic [14:0] req_addr = 0;
  logic [7:0]  req_wdata = 0, rd;
  int          n_errors = 0, num_checks = 0;
  wire         req_ready, rsp_valid, chip_sel_n, write_strobe_n, out_drive_n, data_lines_oe, drv;
  wire [7:0]   rsp_rdata, data_lines_o, mq, dl;
  wire [14:0]  word_index;
  assign dl = data_lines_oe ? (drv ? 8'hxx : data_lines_o) : mq;
  always #4 clk = ~clk;
  asr_ctrl dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
    .word_index(word_index), .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
    .out_drive_n(out_drive_n), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .data_lines_i(dl));
  asr_sram_model ram (.word_index(word_index), .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
    .out_drive_n(out_drive_n), .din(dl), .dout(mq), .drv(drv));
  task automatic xfer(input bit w, input [14:0] a, input [7:0] d);
    int i;
    @(posedge clk) #1;
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
    for (i = 0; i < 40 && !req_ready; i++) @(posedge clk) #1;
    `CHK(req_ready, 1'b1)
    @(posedge clk) #1;
    req_valid = 0;
    for (i = 0; i < 20 && !w && !rsp_valid; i++) @(posedge clk) #1;
    rd = rsp_rdata;
    if (!w) `CHK(rsp_valid, 1'b1)
  endtask
  task automatic t_idle;
    `CHK({req_ready, chip_sel_n, write_strobe_n, out_drive_n, data_lines_oe}, 5'h1e)
  endtask
  task automatic t_edges;
    xfer(1, 15'h7fff, 8'ha5);
    xfer(1, 15'h0000, 8'h5a);
    xfer(0, 15'h7fff, 8'h00);
    `CHK(rd, 8'ha5)
    xfer(0, 15'h0000, 8'h00);
    `CHK(rd, 8'h5a)
  endtask
  task automatic t_reread;
    xfer(1, 15'h1234, 8'h3c);
    xfer(0, 15'h1234, 8'h00);
    xfer(0, 15'h1234, 8'h00);
    `CHK(rd, 8'h3c)
    xfer(1, 15'h1234, 8'hc3);
    xfer(0, 15'h1234, 8'h00);
    `CHK(rd, 8'hc3)
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    t_idle;
    t_edges;
    t_reread;
    tally_and_finish;
  end
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
endmodule
bind asr_ctrl asr_ctrl_asserts chk (.clk(clk), .rst(rst), .rsp_valid(rsp_valid), .word_index(word_index),
  .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n), .out_drive_n(out_drive_n), .data_lines_oe(data_lines_oe));
